// [src/bpo_port_option.sv]
// Port option register of a two-port bridge and the logic it steers.
// Assumes synchronous inputs on sys_clk; registers reached over a plain port.
//
// Local design decision: the plain strobed port.
`default_nettype none
// Notes on behaviour
// - Bit 0 and bits 15:12 read zero, reset zero, ignore writes.
// - Bit 1 set: primary line/multiple read retries match a plain read; reset one.
// - Bit 3 set: secondary line/multiple read retries match a plain read; reset one.
// - Bit 2 set: primary write-invalidate retry matches plain write; reset zero.
// - Bit 4 set: secondary write-invalidate retry matches plain write; reset zero.
// - Bit 5 set: primary read line and read multiple match each other; reset one.
// - Bit 6 set: secondary read line and read multiple match each other; reset one.
// - Bit 7 clear: primary write-invalidate forwarded as plain write; reset zero.
// - Bit 8 clear: secondary write-invalidate forwarded as plain write; reset zero.
// - Bit 9 set: long requests for locked cycles; reset zero.
// - Bit 10 set: secondary master holds request until FIFO empty or terminated.
// - Bit 11 set: primary master holds request until FIFO empty or terminated.
module bpo_port_option (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Retry compare, primary and secondary initiators
  input wire bpo_pkg::bpo_cmp_t p_cmp,
  input wire bpo_pkg::bpo_cmp_t s_cmp,
  output logic p_match,
  output logic s_match,
  // Write-invalidate forwarding; start marks a new forward
  input wire logic p_fwd_start,
  input wire logic [3:0] p_fwd_cmd,
  input wire logic s_fwd_start,
  input wire logic [3:0] s_fwd_cmd,
  output logic [3:0] p_fwd_out_cmd,
  output logic [3:0] s_fwd_out_cmd,
  // Lock handling
  input wire logic lock_start,
  output logic long_lock_req,
  // Internal masters, request outputs active low
  input wire bpo_pkg::bpo_mst_t p_mst,
  input wire bpo_pkg::bpo_mst_t s_mst,
  output logic p_req_n,
  output logic s_req_n
);
  logic [15:0] opt_r;
  logic [15:0] opt_nxt;
  logic p_match_nxt;
  logic s_match_nxt;
  logic [3:0] p_fwd_r;
  logic [3:0] s_fwd_r;
  logic long_lock_r;
  logic p_req_n_r;
  logic s_req_n_r;
  logic p_hold_r;
  logic s_hold_r;
  logic p_req_n_nxt;
  logic s_req_n_nxt;
  wire sel_opt = (reg_addr == bpo_pkg::PORT_OPTION_CONTROL_OFS);
  // Strobes qualified by the option register's address
  wire wr_sel = reg_wr && sel_opt;
  wire rd_sel = reg_rd && sel_opt;
  // Read data is zero off-address so a stray read returns nothing stale
  wire [15:0] rdata_nxt = rd_sel ? opt_r : 16'h0000;

  // Reserved bits must never be writable
  if ((bpo_pkg::PORT_OPTION_WMASK & 16'hf001) != 16'h0000)
  begin : g_chk_rsv
    $error("reserved option bits are writable");
  end

  // Reset value may only set bits that software can write
  if ((bpo_pkg::PORT_OPTION_RESET & ~bpo_pkg::PORT_OPTION_WMASK) != 16'h0000)
  begin : g_chk_reset
    $error("option reset value sets a reserved bit");
  end

  // Every option field must sit on a writable bit
  if (!bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::P_RD_ALIAS_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::P_WR_ALIAS_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::S_RD_ALIAS_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::S_WR_ALIAS_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::P_LM_ALIAS_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::S_LM_ALIAS_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::P_MWI_KEEP_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::S_MWI_KEEP_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::LONG_LOCK_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::S_HOLD_REQ_BIT]
      || !bpo_pkg::PORT_OPTION_WMASK[bpo_pkg::P_HOLD_REQ_BIT])
  begin : g_chk_fields
    $error("option field placed on a reserved bit");
  end

  // Command class of the stored transaction, primary side
  wire p_st_rd = (p_cmp.stored_cmd == bpo_pkg::PLAIN_MEM_READ_CMD);
  wire p_st_wr = (p_cmp.stored_cmd == bpo_pkg::PLAIN_MEM_WRITE_CMD);
  wire p_st_lm = (p_cmp.stored_cmd == bpo_pkg::MEM_READ_LINE_CMD)
    || (p_cmp.stored_cmd == bpo_pkg::MEM_READ_MULTIPLE_CMD);

  // Command class of the retried transaction, primary side
  wire p_rt_lm = (p_cmp.retry_cmd == bpo_pkg::MEM_READ_LINE_CMD)
    || (p_cmp.retry_cmd == bpo_pkg::MEM_READ_MULTIPLE_CMD);
  wire p_rt_wi = (p_cmp.retry_cmd == bpo_pkg::MEM_WRITE_INVALIDATE_CMD);
  wire p_exact = (p_cmp.stored_cmd == p_cmp.retry_cmd);

  // Alias enables, primary side; read live so an edit hits the next retry
  wire p_rd_al = opt_r[bpo_pkg::P_RD_ALIAS_BIT];
  wire p_wr_al = opt_r[bpo_pkg::P_WR_ALIAS_BIT];
  wire p_lm_al = opt_r[bpo_pkg::P_LM_ALIAS_BIT];

  // Alias hits, primary side
  wire p_rd_hit = p_rd_al && p_st_rd && p_rt_lm;
  wire p_wr_hit = p_wr_al && p_st_wr && p_rt_wi;
  wire p_lm_hit = p_lm_al && p_st_lm && p_rt_lm;

  // Primary result; a cycle without a valid request never matches
  assign p_match_nxt = p_cmp.valid
    && (p_exact || p_rd_hit || p_wr_hit || p_lm_hit);

  // Command class of the stored transaction, secondary side
  wire s_st_rd = (s_cmp.stored_cmd == bpo_pkg::PLAIN_MEM_READ_CMD);
  wire s_st_wr = (s_cmp.stored_cmd == bpo_pkg::PLAIN_MEM_WRITE_CMD);
  wire s_st_lm = (s_cmp.stored_cmd == bpo_pkg::MEM_READ_LINE_CMD)
    || (s_cmp.stored_cmd == bpo_pkg::MEM_READ_MULTIPLE_CMD);

  // Command class of the retried transaction, secondary side
  wire s_rt_lm = (s_cmp.retry_cmd == bpo_pkg::MEM_READ_LINE_CMD)
    || (s_cmp.retry_cmd == bpo_pkg::MEM_READ_MULTIPLE_CMD);
  wire s_rt_wi = (s_cmp.retry_cmd == bpo_pkg::MEM_WRITE_INVALIDATE_CMD);
  wire s_exact = (s_cmp.stored_cmd == s_cmp.retry_cmd);

  // Alias enables, secondary side
  wire s_rd_al = opt_r[bpo_pkg::S_RD_ALIAS_BIT];
  wire s_wr_al = opt_r[bpo_pkg::S_WR_ALIAS_BIT];
  wire s_lm_al = opt_r[bpo_pkg::S_LM_ALIAS_BIT];

  // Alias hits, secondary side
  wire s_rd_hit = s_rd_al && s_st_rd && s_rt_lm;
  wire s_wr_hit = s_wr_al && s_st_wr && s_rt_wi;
  wire s_lm_hit = s_lm_al && s_st_lm && s_rt_lm;

  // Secondary result
  assign s_match_nxt = s_cmp.valid
    && (s_exact || s_rd_hit || s_wr_hit || s_lm_hit);

  // Write merge; reserved bits masked to zero
  assign opt_nxt = wr_sel ? (reg_wdata & bpo_pkg::PORT_OPTION_WMASK) : opt_r;

  // Primary master: its work is done once the FIFO drains or a target ends it
  wire p_want = p_mst.want_bus;
  wire p_done = p_mst.fifo_empty || p_mst.target_term;
  // Hold mode keeps the request until done; normal mode drops it on frame
  wire p_keep = p_hold_r ? !p_done : !p_mst.frame_seen;
  assign p_req_n_nxt = !(p_want && p_keep);

  // Secondary master, same scheme with its own hold mode
  wire s_want = s_mst.want_bus;
  wire s_done = s_mst.fifo_empty || s_mst.target_term;
  wire s_keep = s_hold_r ? !s_done : !s_mst.frame_seen;
  assign s_req_n_nxt = !(s_want && s_keep);

  // Option register and read data
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      opt_r <= bpo_pkg::PORT_OPTION_RESET;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      opt_r <= opt_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // Compare results
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      p_match <= 1'b0;
      s_match <= 1'b0;
    end
    else
    begin
      p_match <= p_match_nxt;
      s_match <= s_match_nxt;
    end
  end

  // Primary forward: write-invalidate becomes plain write unless kept
  wire p_fwd_is_wi = (p_fwd_cmd == bpo_pkg::MEM_WRITE_INVALIDATE_CMD);
  wire p_fwd_keep = opt_r[bpo_pkg::P_MWI_KEEP_BIT];
  wire [3:0] p_fwd_nxt = (p_fwd_is_wi && !p_fwd_keep)
    ? bpo_pkg::PLAIN_MEM_WRITE_CMD : p_fwd_cmd;

  // Primary command latched per transaction so later edits never disturb it
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      p_fwd_r <= 4'h0;
    end
    else if (p_fwd_start)
    begin
      p_fwd_r <= p_fwd_nxt;
    end
  end

  // Secondary forward: same conversion under its own keep bit
  wire s_fwd_is_wi = (s_fwd_cmd == bpo_pkg::MEM_WRITE_INVALIDATE_CMD);
  wire s_fwd_keep = opt_r[bpo_pkg::S_MWI_KEEP_BIT];
  wire [3:0] s_fwd_nxt = (s_fwd_is_wi && !s_fwd_keep)
    ? bpo_pkg::PLAIN_MEM_WRITE_CMD : s_fwd_cmd;

  // Secondary command latched per transaction
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_fwd_r <= 4'h0;
    end
    else if (s_fwd_start)
    begin
      s_fwd_r <= s_fwd_nxt;
    end
  end

  // Lock mode captured at the start of a locked sequence only
  wire long_lock_nxt = lock_start ? opt_r[bpo_pkg::LONG_LOCK_BIT] : long_lock_r;

  // Lock mode register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      long_lock_r <= 1'b0;
    end
    else
    begin
      long_lock_r <= long_lock_nxt;
    end
  end

  // Hold modes follow the option only while idle, so a live request keeps its mode
  wire p_hold_nxt = p_want ? p_hold_r : opt_r[bpo_pkg::P_HOLD_REQ_BIT];
  wire s_hold_nxt = s_want ? s_hold_r : opt_r[bpo_pkg::S_HOLD_REQ_BIT];

  // Primary hold mode register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      p_hold_r <= bpo_pkg::PORT_OPTION_RESET[bpo_pkg::P_HOLD_REQ_BIT];
    end
    else
    begin
      p_hold_r <= p_hold_nxt;
    end
  end

  // Secondary hold mode register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_hold_r <= bpo_pkg::PORT_OPTION_RESET[bpo_pkg::S_HOLD_REQ_BIT];
    end
    else
    begin
      s_hold_r <= s_hold_nxt;
    end
  end

  // Bus requests, idle high out of reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      p_req_n_r <= 1'b1;
      s_req_n_r <= 1'b1;
    end
    else
    begin
      p_req_n_r <= p_req_n_nxt;
      s_req_n_r <= s_req_n_nxt;
    end
  end

  // Outputs straight from their registers
  assign p_fwd_out_cmd = p_fwd_r;
  assign s_fwd_out_cmd = s_fwd_r;
  assign long_lock_req = long_lock_r;
  assign p_req_n = p_req_n_r;
  assign s_req_n = s_req_n_r;
endmodule // bpo_port_option
`default_nettype wire

// [src/bpo_pkg.sv]
// Package for the bridge port option control block.
// Assumes a plain register port and one PCI-rate clock.
`default_nettype none
package bpo_pkg;
  // Register map
  localparam logic [7:0] PORT_OPTION_CONTROL_OFS = 8'h74;
  localparam logic [15:0] PORT_OPTION_RESET = 16'h0c6a;
  localparam logic [15:0] PORT_OPTION_WMASK = 16'h0ffe;
  // Field positions
  localparam int P_RD_ALIAS_BIT = 1;
  localparam int P_WR_ALIAS_BIT = 2;
  localparam int S_RD_ALIAS_BIT = 3;
  localparam int S_WR_ALIAS_BIT = 4;
  localparam int P_LM_ALIAS_BIT = 5;
  localparam int S_LM_ALIAS_BIT = 6;
  localparam int P_MWI_KEEP_BIT = 7;
  localparam int S_MWI_KEEP_BIT = 8;
  localparam int LONG_LOCK_BIT = 9;
  localparam int S_HOLD_REQ_BIT = 10;
  localparam int P_HOLD_REQ_BIT = 11;
  // PCI command codes
  localparam logic [3:0] PLAIN_MEM_READ_CMD = 4'h6;
  localparam logic [3:0] PLAIN_MEM_WRITE_CMD = 4'h7;
  localparam logic [3:0] MEM_READ_MULTIPLE_CMD = 4'hc;
  localparam logic [3:0] MEM_READ_LINE_CMD = 4'he;
  localparam logic [3:0] MEM_WRITE_INVALIDATE_CMD = 4'hf;
  // Retry compare request: stored and retried commands
  typedef struct packed {
    logic valid;
    logic [3:0] stored_cmd;
    logic [3:0] retry_cmd;
  } bpo_cmp_t;
  // Bus master request-hold status
  typedef struct packed {
    logic want_bus;
    logic frame_seen;
    logic fifo_empty;
    logic target_term;
  } bpo_mst_t;
endpackage : bpo_pkg
`default_nettype wire

// [sim/bpo_bus_model.sv]
// Far-side bus model: an initiator wanting the bus, a FIFO that drains.
// Assumes the bridge's active-low request and the shared clock.
`default_nettype none
module bpo_bus_model (
  // Clock, reset, stimulus
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic go,
  // Request in, status out
  input wire logic req_n,
  output var bpo_pkg::bpo_mst_t mst
);
  logic [2:0] cnt_r;
  // Frame one cycle after grant, FIFO empty four cycles later
  always_ff @(posedge sys_clk)
    if (sys_rst || !go) cnt_r <= 3'h0;
    else if ((!req_n || cnt_r != 3'h0) && cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
  assign mst = '{go, cnt_r != 3'h0, cnt_r > 3'h4, 1'b0};
endmodule // bpo_bus_model
`default_nettype wire

// [sim/bpo_port_option_sva.sv]
// Checker for the port option block's output timing.
// Assumes it is bound to the top module and sees its ports only.
`default_nettype none
module bpo_port_option_sva (
  // Watched ports
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire bpo_pkg::bpo_cmp_t p_cmp,
  input wire bpo_pkg::bpo_cmp_t s_cmp,
  input wire logic p_match,
  input wire logic s_match,
  input wire logic p_fwd_start,
  input wire logic [3:0] p_fwd_cmd,
  input wire logic [3:0] p_fwd_out_cmd,
  input wire bpo_pkg::bpo_mst_t p_mst,
  input wire logic p_req_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Register and compare timing
  property p_rz; !reg_rd |=> reg_rdata == 16'h0; endproperty
  a_rz: assert property (p_rz) else $error("rdata idle");
  property p_rsv; reg_rd |=> reg_rdata[0] == 1'b0 && reg_rdata[15:12] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_pe; p_cmp.valid && p_cmp.stored_cmd == p_cmp.retry_cmd |=> p_match; endproperty
  a_pe: assert property (p_pe) else $error("primary exact");
  property p_se; s_cmp.valid && s_cmp.stored_cmd == s_cmp.retry_cmd |=> s_match; endproperty
  a_se: assert property (p_se) else $error("secondary exact");
  property p_nv; !p_cmp.valid |=> !p_match; endproperty
  a_nv: assert property (p_nv) else $error("match w/o valid");
  // Forwarding and request
  property p_fw; p_fwd_start && p_fwd_cmd != 4'hf |=> p_fwd_out_cmd == $past(p_fwd_cmd); endproperty
  a_fw: assert property (p_fw) else $error("forward cmd");
  property p_fs; !p_fwd_start |=> $stable(p_fwd_out_cmd); endproperty
  a_fs: assert property (p_fs) else $error("forward moved");
  property p_rq; !p_mst.want_bus |=> p_req_n; endproperty
  a_rq: assert property (p_rq) else $error("request idle");
  cover property (p_match);
  cover property (!p_req_n);
  cover property (p_fwd_start);
endmodule // bpo_port_option_sva
bind bpo_port_option bpo_port_option_sva u_sva (.*);
`default_nettype wire

// [sim/test_bridge_port_option_control.sv]
// Self-checking bench for the port option block.
// Assumes two far-side bus models driving the master status.
`default_nettype none
module test_bridge_port_option_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  bpo_pkg::bpo_cmp_t p_cmp = '0, s_cmp = '0;
  logic p_fwd_start = 1'b0, s_fwd_start = 1'b0, lock_start = 1'b0;
  logic [3:0] p_fwd_cmd = 4'h0, s_fwd_cmd = 4'h0, p_fwd_out_cmd, s_fwd_out_cmd;
  logic p_match, s_match, long_lock_req, p_req_n, s_req_n;
  bpo_pkg::bpo_mst_t p_mst, s_mst;
  logic [3:0] cmds [5] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf};
  int bad_count = 0, n_tests = 0;
  // Clock, design, far side
  always #4 sys_clk = ~sys_clk;
  bpo_port_option u_bpo_port_option (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .p_cmp, .s_cmp, .p_match, .s_match,
    .p_fwd_start, .p_fwd_cmd, .s_fwd_start, .s_fwd_cmd, .p_fwd_out_cmd, .s_fwd_out_cmd,
    .lock_start, .long_lock_req, .p_mst, .s_mst, .p_req_n, .s_req_n
  );
  bpo_bus_model u_pbus (.sys_clk, .sys_rst, .go, .req_n(p_req_n), .mst(p_mst));
  bpo_bus_model u_sbus (.sys_clk, .sys_rst, .go, .req_n(s_req_n), .mst(s_mst));
  task summarize;
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [15:0] e);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // Expected retry match from option bits {line/multi, write, read}
  function automatic logic em(logic [2:0] o, logic [3:0] s, logic [3:0] r);
    logic s_lm, r_lm;
    s_lm = s == bpo_pkg::MEM_READ_LINE_CMD || s == bpo_pkg::MEM_READ_MULTIPLE_CMD;
    r_lm = r == bpo_pkg::MEM_READ_LINE_CMD || r == bpo_pkg::MEM_READ_MULTIPLE_CMD;
    return s == r || (o[0] && s == bpo_pkg::PLAIN_MEM_READ_CMD && r_lm)
      || (o[1] && s == bpo_pkg::PLAIN_MEM_WRITE_CMD
          && r == bpo_pkg::MEM_WRITE_INVALIDATE_CMD)
      || (o[2] && s_lm && r_lm);
  endfunction
  task t_cmp(logic [15:0] o);
    wr(8'h74, o);
    foreach (cmds[i])
      foreach (cmds[j])
      begin
        @(posedge sys_clk) {p_cmp, s_cmp} <= {2{1'b1, cmds[i], cmds[j]}};
        @(posedge sys_clk) {p_cmp, s_cmp} <= '0;
        #1 chk("p_match", 16'(em({o[5], o[2], o[1]}, cmds[i], cmds[j])), 16'(p_match));
        chk("s_match", 16'(em({o[6], o[4], o[3]}, cmds[i], cmds[j])), 16'(s_match));
      end
  endtask
  task t_fwd(logic [15:0] o, logic [3:0] c, logic [3:0] pe, logic [3:0] se);
    wr(8'h74, o);
    @(posedge sys_clk) {p_fwd_start, s_fwd_start, p_fwd_cmd, s_fwd_cmd} <= {2'h3, c, c};
    @(posedge sys_clk) {p_fwd_start, s_fwd_start} <= 2'h0;
    wr(8'h74, o ^ 16'h0180);
    chk("p_fwd", 16'(pe), 16'(p_fwd_out_cmd));
    chk("s_fwd", 16'(se), 16'(s_fwd_out_cmd));
  endtask
  task t_lock(logic [15:0] o);
    wr(8'h74, o);
    @(posedge sys_clk) lock_start <= 1'b1;
    @(posedge sys_clk) lock_start <= 1'b0;
    #1 chk("long_lock", 16'(o[9]), 16'(long_lock_req));
  endtask
  task t_req(logic [15:0] o, logic pe, logic se);
    wr(8'h74, o);
    @(posedge sys_clk) go <= 1'b1;
    for (int k = 0; k < 8 && p_req_n !== 1'b0; k++) @(posedge sys_clk) #1;
    if (p_req_n !== 1'b0)
    begin
      bad_count++;
      summarize();
    end
    repeat (3) @(posedge sys_clk);
    #1 chk("p_req_n", 16'(pe), 16'(p_req_n));
    chk("s_req_n", 16'(se), 16'(s_req_n));
    repeat (4) @(posedge sys_clk);
    #1 chk("p_req_n", 16'h0001, 16'(p_req_n));
    chk("s_req_n", 16'h0001, 16'(s_req_n));
    @(posedge sys_clk) go <= 1'b0;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h74, 16'h0c6a);
    wr(8'h74, 16'hffff);
    rd(8'h74, 16'h0ffe);
    wr(8'h70, 16'hffff);
    rd(8'h70, 16'h0000);
    t_cmp(16'h002a);
    t_cmp(16'h0054);
    t_fwd(16'h0000, 4'hf, 4'h7, 4'h7);
    t_fwd(16'h0080, 4'hf, 4'hf, 4'h7);
    t_fwd(16'h0100, 4'hf, 4'h7, 4'hf);
    t_fwd(16'h0180, 4'h7, 4'h7, 4'h7);
    t_lock(16'h0200);
    t_lock(16'h0000);
    t_req(16'h0800, 1'b0, 1'b1);
    t_req(16'h0400, 1'b1, 1'b0);
    summarize();
  end
endmodule // test_bridge_port_option_control
`default_nettype wire
